// ===== inc/kbl_consts.svh
/*
 * byte codes, field positions and timing counts of the keyboard link protocol.
 * assumes: included by the design file and the bench, by bare name.
 */
`ifndef KBL_CONSTS_SVH
`define KBL_CONSTS_SVH
// one-byte link codes
`define KBL_RESTART_CODE 8'hff
`define KBL_RESET_ACK_ONE 8'hfe
`define KBL_RESET_ACK_TWO 8'hfd
`define KBL_FIRST_BYTE_ACK 8'h3f
`define KBL_QUIET_ACK 8'h30
`define KBL_SCAN_ACK 8'h31
`define KBL_MOUSE_ACK 8'h32
`define KBL_SCAN_AND_MOUSE_ACK 8'h33
`define KBL_MOUSE_POSITION_REQUEST 8'h22
`define KBL_SPARE_CMD 8'h21
// upper nibbles; the led code is the upper five bits
`define KBL_ACK_NIBBLE 4'h3
`define KBL_KEY_DOWN_PREFIX 4'hc
`define KBL_KEY_UP_PREFIX 4'hd
`define KBL_LED_NIBBLE 5'h00
// mouse count limits (signed 7 bit)
`define KBL_COUNT_MAX 7'h3f
`define KBL_COUNT_MIN 7'h40
// reply timeout, left as a cycle count
`define KBL_ACK_TIMEOUT_CYC 16'h0400
`endif

// ===== inc/kbl_pkg.sv
/*
 * types shared by the keyboard link protocol block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package kbl_pkg;
    // protocol states, one-hot
    typedef enum logic [8:0] {
        KBL_ST_ERR = 9'h001, // restart code sent, waiting for host restart
        KBL_ST_R0 = 9'h002, // waiting first reset ack
        KBL_ST_R1 = 9'h004, // waiting second reset ack
        KBL_ST_R2 = 9'h008, // waiting mode ack
        KBL_ST_IDLE = 9'h010, // free to send
        KBL_ST_K1 = 9'h020, // row byte out, waiting byte ack
        KBL_ST_K2 = 9'h040, // column byte out, waiting final ack
        KBL_ST_M1 = 9'h080, // x count out, waiting byte ack
        KBL_ST_M2 = 9'h100 // y count out, waiting final ack
    } kbl_state_t;
    // one key change from the matrix scanner
    typedef struct packed {
        logic down;
        logic [3:0] row;
        logic [3:0] col;
    } kbl_key_t;
    // single count steps from the quadrature decoder
    typedef struct packed {
        logic x_inc;
        logic x_dec;
        logic y_inc;
        logic y_dec;
    } kbl_step_t;
endpackage
`default_nettype wire

// ===== src/kbl_link.sv
/*
 * keyboard controller link protocol: restart sequence, key packets,
 * mouse packets, mode acks and led command, over a byte-wide link.
 * assumes: rx/tx byte ports and scanner/decoder inputs are on i_clk;
 * only i_user_rst comes from a pin.
 */
`default_nettype none
`include "kbl_consts.svh"

module kbl_link (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_user_rst,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic i_key_valid,
    input wire kbl_pkg::kbl_key_t i_key,
    output logic o_key_ready,
    output logic o_key_clear,
    input wire kbl_pkg::kbl_step_t i_step,
    output logic o_scan_en,
    output logic o_mouse_auto,
    output logic [2:0] o_leds,
    output logic o_ack_timeout
);
    kbl_pkg::kbl_state_t state; // protocol state
    kbl_pkg::kbl_state_t next_state;
    logic [1:0] urst_sync; // user reset synchroniser
    logic urst_seen; // delayed copy for edge detect
    logic mouse_req; // pending position request
    logic [6:0] cnt_x; // accumulated x movement
    logic [6:0] cnt_y; // accumulated y movement
    logic [6:0] hold_y; // y captured for second byte
    logic [3:0] hold_col; // column captured for second byte
    logic [15:0] to_cnt; // reply wait counter

    // decoded received byte
    wire logic [7:0] rx = i_rx_data;
    wire logic rx_restart = i_rx_valid && rx == `KBL_RESTART_CODE;
    wire logic rx_rq = i_rx_valid && rx == `KBL_MOUSE_POSITION_REQUEST;
    wire logic rx_led = i_rx_valid && rx[7:3] == `KBL_LED_NIBBLE;
    wire logic rx_spare = i_rx_valid && rx == `KBL_SPARE_CMD;
    wire logic rx_cmd = rx_rq || rx_led || rx_spare;
    wire logic rx_final = i_rx_valid && rx[7:4] == `KBL_ACK_NIBBLE && rx[3:2] == 2'b00;
    wire logic rx_back = i_rx_valid && rx == `KBL_FIRST_BYTE_ACK;
    wire logic rx_other = i_rx_valid && !rx_restart && !rx_cmd; // expects ack
    wire logic user_edge = urst_sync[1] && !urst_seen;
    wire logic tx_free = !o_tx_valid || i_tx_ready;
    wire logic locked = cnt_x == `KBL_COUNT_MAX || cnt_x == `KBL_COUNT_MIN
        || cnt_y == `KBL_COUNT_MAX || cnt_y == `KBL_COUNT_MIN;
    wire logic mouse_has = cnt_x != 7'h00 || cnt_y != 7'h00;
    wire logic mouse_want = mouse_req || (o_mouse_auto && mouse_has);
    wire logic idle_free = state == kbl_pkg::KBL_ST_IDLE && tx_free;
    wire logic take_mouse = idle_free && mouse_want && (locked || !i_key_valid || !o_scan_en);
    wire logic take_key = idle_free && i_key_valid && o_scan_en && !take_mouse;
    wire logic wait_st = state inside {kbl_pkg::KBL_ST_K1, kbl_pkg::KBL_ST_K2,
        kbl_pkg::KBL_ST_M1, kbl_pkg::KBL_ST_M2, kbl_pkg::KBL_ST_R2};
    wire logic rst_wait = state inside {kbl_pkg::KBL_ST_ERR, kbl_pkg::KBL_ST_R0};
    // error: wrong reply in any waiting state
    wire logic err_r0 = state == kbl_pkg::KBL_ST_R0 && rx_other
        && rx != `KBL_RESET_ACK_ONE;
    wire logic err_r1 = state == kbl_pkg::KBL_ST_R1 && rx_other
        && rx != `KBL_RESET_ACK_TWO;
    wire logic err_ack = (state inside {kbl_pkg::KBL_ST_K1, kbl_pkg::KBL_ST_M1}
        && rx_other && !rx_back)
        || (state inside {kbl_pkg::KBL_ST_K2, kbl_pkg::KBL_ST_M2, kbl_pkg::KBL_ST_R2}
        && rx_other && !rx_final);
    wire logic err_resend = (state == kbl_pkg::KBL_ST_ERR && i_rx_valid && !rx_restart)
        || err_r0 || err_r1 || err_ack || user_edge;
    // restart on host restart code unless a user reset edge arrives in the same cycle
    wire logic restart = rx_restart && !user_edge;
    wire logic final_ok = wait_st && !(state inside {kbl_pkg::KBL_ST_K1,
        kbl_pkg::KBL_ST_M1}) && rx_final && !restart;
    wire logic back_ok = state inside {kbl_pkg::KBL_ST_K1, kbl_pkg::KBL_ST_M1}
        && rx_back && !restart;
    wire logic cap = take_mouse && !restart && !err_resend;

    // next state
    always_comb begin
        next_state = state;
        case (state)
            kbl_pkg::KBL_ST_ERR: next_state = kbl_pkg::KBL_ST_ERR;
            kbl_pkg::KBL_ST_R0: begin
                if (i_rx_valid && rx == `KBL_RESET_ACK_ONE) begin
                    next_state = kbl_pkg::KBL_ST_R1;
                end
            end
            kbl_pkg::KBL_ST_R1: begin
                if (i_rx_valid && rx == `KBL_RESET_ACK_TWO) begin
                    next_state = kbl_pkg::KBL_ST_R2;
                end
            end
            kbl_pkg::KBL_ST_K1: if (back_ok) next_state = kbl_pkg::KBL_ST_K2;
            kbl_pkg::KBL_ST_M1: if (back_ok) next_state = kbl_pkg::KBL_ST_M2;
            kbl_pkg::KBL_ST_IDLE: begin
                if (take_mouse) begin
                    next_state = kbl_pkg::KBL_ST_M1;
                end else if (take_key) begin
                    next_state = kbl_pkg::KBL_ST_K1;
                end
            end
            kbl_pkg::KBL_ST_R2, kbl_pkg::KBL_ST_K2, kbl_pkg::KBL_ST_M2: begin
                if (final_ok) next_state = kbl_pkg::KBL_ST_IDLE;
            end
            default: next_state = kbl_pkg::KBL_ST_ERR;
        endcase
        if (restart) begin
            next_state = kbl_pkg::KBL_ST_R0;
        end else if (err_resend) begin
            next_state = kbl_pkg::KBL_ST_ERR;
        end
    end

    // user reset pin: two flip-flops, then edge detect on the second
    always_ff @(posedge i_clk) begin
        urst_sync <= {urst_sync[0], i_user_rst};
        urst_seen <= urst_sync[1];
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_srst) state <= kbl_pkg::KBL_ST_ERR;
        else state <= next_state;
    end

    // transmit byte; restart code overrides a pending byte
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= `KBL_RESTART_CODE;
        end else if (restart || err_resend) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= `KBL_RESTART_CODE;
        end else if (state == kbl_pkg::KBL_ST_R0 && i_rx_valid) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= `KBL_RESET_ACK_ONE;
        end else if (state == kbl_pkg::KBL_ST_R1 && i_rx_valid
            && rx == `KBL_RESET_ACK_TWO) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= `KBL_RESET_ACK_TWO;
        end else if (back_ok && state == kbl_pkg::KBL_ST_K1) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= {o_tx_data[7:4], hold_col};
        end else if (back_ok) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= {1'b0, hold_y};
        end else if (cap) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= {1'b0, cnt_x};
        end else if (take_key && !restart && !err_resend) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= {i_key.down ? `KBL_KEY_DOWN_PREFIX : `KBL_KEY_UP_PREFIX, i_key.row};
        end else if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
        end
    end

    // key column held for the second byte
    always_ff @(posedge i_clk) begin
        if (take_key) hold_col <= i_key.col;
    end

    // modes: cleared by restart, set by final acks
    always_ff @(posedge i_clk) begin
        if (i_srst || restart) begin
            o_scan_en <= 1'b0;
            o_mouse_auto <= 1'b0;
        end else if (final_ok) begin
            o_scan_en <= rx[0];
            o_mouse_auto <= rx[1];
        end else if (state == kbl_pkg::KBL_ST_R2 && !final_ok) begin
            o_scan_en <= o_scan_en;
        end else if (take_key || cap) begin
            o_scan_en <= 1'b0;
            o_mouse_auto <= cap ? 1'b0 : o_mouse_auto;
        end
    end

    // mouse counters: accumulate, lock at a limit; on capture a step that
    // arrives in the same cycle starts the next count instead of being lost
    always_ff @(posedge i_clk) begin
        if (i_srst || restart) begin
            cnt_x <= 7'h00;
            cnt_y <= 7'h00;
        end else if (cap) begin
            cnt_x <= {6'h00, i_step.x_inc} - {6'h00, i_step.x_dec};
            cnt_y <= {6'h00, i_step.y_inc} - {6'h00, i_step.y_dec};
            hold_y <= cnt_y;
        end else if (!locked) begin
            cnt_x <= cnt_x + {6'h00, i_step.x_inc} - {6'h00, i_step.x_dec};
            cnt_y <= cnt_y + {6'h00, i_step.y_inc} - {6'h00, i_step.y_dec};
        end
    end

    // position request held until a mouse set goes out
    always_ff @(posedge i_clk) begin
        if (i_srst || restart) mouse_req <= 1'b0;
        else if (rx_rq) mouse_req <= 1'b1;
        else if (cap) mouse_req <= 1'b0;
    end

    // led command; a protocol restart leaves it alone
    always_ff @(posedge i_clk) begin
        if (i_srst) o_leds <= 3'h0;
        else if (rx_led) o_leds <= rx[2:0];
    end

    // key flags released at restart
    always_ff @(posedge i_clk) begin
        if (i_srst) o_key_clear <= 1'b0;
        else o_key_clear <= restart;
    end

    // reply timer while waiting for host restart or first reset ack; timeout only flagged
    always_ff @(posedge i_clk) begin
        if (i_srst || !rst_wait || i_rx_valid) begin
            to_cnt <= 16'h0000;
            o_ack_timeout <= 1'b0;
        end else if (to_cnt == `KBL_ACK_TIMEOUT_CYC - 16'h0001) begin
            to_cnt <= 16'h0000;
            o_ack_timeout <= 1'b1;
        end else begin
            to_cnt <= to_cnt + 16'h0001;
            o_ack_timeout <= 1'b0;
        end
    end

    // scanner is stalled while a key byte cannot go; dropped when scan off
    assign o_key_ready = !o_scan_en || take_key;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid)
        else $error("tx byte dropped before ready");
    restart_clear_a: assert property (restart |=> cnt_x == 7'h00 && !o_scan_en
        && o_key_clear && o_tx_data == `KBL_RESTART_CODE) else $error("restart incomplete");
    ack_echo_a: assert property (state == kbl_pkg::KBL_ST_R0 && i_rx_valid
        && rx == `KBL_RESET_ACK_ONE |=> state == kbl_pkg::KBL_ST_R1
        && o_tx_data == `KBL_RESET_ACK_ONE) else $error("first reset ack not echoed");
    err_resend_a: assert property (state == kbl_pkg::KBL_ST_ERR && i_rx_valid
        && !rx_restart |=> o_tx_valid && o_tx_data == `KBL_RESTART_CODE)
        else $error("restart code not resent");
    mode_set_a: assert property (state == kbl_pkg::KBL_ST_R2 && i_rx_valid
        && rx == `KBL_SCAN_ACK |=> o_scan_en && !o_mouse_auto
        && state == kbl_pkg::KBL_ST_IDLE) else $error("scan ack mode wrong");
    key_row_a: assert property (take_key && !restart && !err_resend
        |=> o_tx_data[3:0] == $past(i_key.row) && state == kbl_pkg::KBL_ST_K1)
        else $error("row byte wrong");
    back_err_a: assert property (state == kbl_pkg::KBL_ST_K1 && rx_other
        && !rx_back |=> state == kbl_pkg::KBL_ST_ERR) else $error("bad byte ack kept");
    mouse_gate_a: assert property (cap |-> mouse_req || o_mouse_auto)
        else $error("mouse sent without permission");
    accum_a: assert property (!locked && !cap && !restart && i_step == 4'b1000
        |=> cnt_x == $past(cnt_x) + 7'h01) else $error("x step lost");
    key_gate_a: assert property (take_key |-> o_scan_en)
        else $error("key sent with scan off");
    user_restart_a: assert property (user_edge |=> state == kbl_pkg::KBL_ST_ERR
        && o_tx_valid && o_tx_data == `KBL_RESTART_CODE) else $error("user reset not signalled");
    timeout_span_a: assert property (o_ack_timeout |-> rst_wait
        && $past(to_cnt) == `KBL_ACK_TIMEOUT_CYC - 16'h0001) else $error("timeout span wrong");
    reset_done_c: cover property (state == kbl_pkg::KBL_ST_R2 ##1
        state == kbl_pkg::KBL_ST_IDLE);
    key_pkt_c: cover property (state == kbl_pkg::KBL_ST_K2 ##1
        state == kbl_pkg::KBL_ST_IDLE);
    mouse_pkt_c: cover property (state == kbl_pkg::KBL_ST_M2 ##1
        state == kbl_pkg::KBL_ST_IDLE);
    timeout_c: cover property (o_ack_timeout);
endmodule // kbl_link
`default_nettype wire

// ===== verif/kbl_host_model.sv
/*
 * host side of the keyboard link: takes controller bytes, stalls at random,
 * sends host codes as one-cycle pulses.
 * assumes: one clock shared with the controller; inputs change at falling edges.
 */
`default_nettype none
module kbl_host_model (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$]; // bytes taken from the controller
    logic [7:0] last_data = 8'h00; // byte seen at the last edge
    logic last_wait = 1'b0; // a byte was waiting at the last edge
    int hold_errs = 0; // stalled bytes that changed
    initial begin
        o_tx_ready = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
    end
    // take bytes; a stalled byte must hold unless the restart code overrides it
    always @(posedge i_clk) begin
        if (i_tx_valid === 1'b1 && o_tx_ready) got_q.push_back(i_tx_data);
        if (last_wait && i_tx_valid && i_tx_data !== last_data && i_tx_data !== 8'hff) begin
            hold_errs++;
        end
        last_wait = (i_tx_valid === 1'b1) && !o_tx_ready;
        last_data = i_tx_data;
    end
    // ready drops now and then, and stays low while stalled
    always @(negedge i_clk) o_tx_ready <= !i_stall && ($urandom % 4 != 0);
    // one host code, then the line shows the inverse value
    task automatic send(input logic [7:0] b);
        @(negedge i_clk);
        o_rx_valid = 1'b1;
        o_rx_data = b;
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_data = ~b;
    endtask
endmodule // kbl_host_model
`default_nettype wire

// ===== verif/kbl_link_tb.sv
/*
 * self-checking bench for the keyboard link protocol block.
 * assumes: host model in kbl_host_model; counts and modes modelled here.
 */
`default_nettype none
`include "kbl_consts.svh"
module kbl_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk;
    logic i_srst;
    logic i_user_rst;
    logic stall; // holds host ready low
    logic i_key_valid;
    kbl_pkg::kbl_key_t i_key;
    kbl_pkg::kbl_step_t i_step;
    logic rx_valid, tx_valid, tx_ready, key_ready, key_clear, scan_en, mouse_auto, ack_to;
    logic [7:0] rx_data, tx_data;
    logic [2:0] leds;
    int mismatches = 0;
    int checks_done = 0;
    int clears = 0; // key release pulses seen
    int mx = 0; // model x count
    int my = 0; // model y count
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (key_clear === 1'b1) clears++;
    kbl_link dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_user_rst(i_user_rst),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .i_tx_ready(tx_ready), .i_key_valid(i_key_valid),
        .i_key(i_key), .o_key_ready(key_ready), .o_key_clear(key_clear), .i_step(i_step),
        .o_scan_en(scan_en), .o_mouse_auto(mouse_auto), .o_leds(leds), .o_ack_timeout(ack_to));
    kbl_host_model host_u (.i_clk(i_clk), .i_stall(stall), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data));
    // compare one value and count it
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // wait a bounded time for the next controller byte
    task automatic expect_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (host_u.got_q.size() == 0 && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        if (host_u.got_q.size() == 0) check(~exp, exp, "missing byte");
        else check(host_u.got_q.pop_front(), exp, "tx byte");
    endtask
    // nothing may leave the controller for a while
    task automatic expect_none;
        repeat (40) @(posedge i_clk);
        check(8'(host_u.got_q.size()), 8'h00, "extra byte");
    endtask
    // modes after a final ack
    task automatic check_modes(input logic [7:0] fin);
        repeat (3) @(negedge i_clk);
        check({6'h00, mouse_auto, scan_en}, {6'h00, fin[1:0]}, "modes");
    endtask
    // full restart handshake ending with a mode ack
    task automatic restart(input logic [7:0] fin);
        int c0;
        c0 = clears;
        host_u.send(8'hff);
        expect_tx(8'hff);
        host_u.send(8'hfe);
        expect_tx(8'hfe);
        host_u.send(8'hfd);
        expect_tx(8'hfd);
        host_u.send(fin);
        check_modes(fin);
        check(8'(clears - c0), 8'h01, "key release");
        mx = 0;
        my = 0;
    endtask
    // hold a key change until the controller takes it
    task automatic offer_key(input kbl_pkg::kbl_key_t k);
        logic rdy;
        int n;
        rdy = 1'b0;
        n = 0;
        @(negedge i_clk);
        i_key_valid = 1'b1;
        i_key = k;
        while (rdy !== 1'b1 && n < 200) begin
            #1 rdy = key_ready;
            @(negedge i_clk);
            n++;
        end
        i_key_valid = 1'b0;
    endtask
    // two-byte key report with host acks
    task automatic key_packet(input logic down, input logic [7:0] ack1, input logic [7:0] fin);
        kbl_pkg::kbl_key_t k;
        k.down = down;
        k.row = 4'($urandom);
        k.col = 4'($urandom);
        offer_key(k);
        expect_tx({down ? 4'hc : 4'hd, k.row});
        host_u.send(ack1);
        if (ack1 != 8'h3f) begin
            expect_tx(8'hff);
        end else begin
            expect_tx({down ? 4'hc : 4'hd, k.col});
            host_u.send(fin);
            check_modes(fin);
        end
    endtask
    // one count step pulse, tracked in the model
    task automatic step(input kbl_pkg::kbl_step_t s);
        @(negedge i_clk);
        i_step = s;
        @(negedge i_clk);
        i_step = '0;
        mx += int'(s.x_inc) - int'(s.x_dec);
        my += int'(s.y_inc) - int'(s.y_dec);
    endtask
    // two-byte mouse report with host acks
    task automatic mouse_packet(input logic [7:0] fin);
        expect_tx({1'b0, 7'(mx)});
        host_u.send(8'h3f);
        expect_tx({1'b0, 7'(my)});
        host_u.send(fin);
        check_modes(fin);
        mx = 0;
        my = 0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end
    initial begin
        int n;
        i_clk = 1'b0;
        i_srst = 1'b1;
        i_user_rst = 1'b0;
        stall = 1'b1; // no byte leaves while reset holds the restart code
        i_key_valid = 1'b0;
        i_key = '0;
        i_step = '0;
        void'($urandom(57));
        repeat (10) @(negedge i_clk);
        i_srst = 1'b0;
        stall = 1'b0;
        // silent host: the timeout pulse comes after the set span, nothing is resent
        n = 0;
        while (ack_to !== 1'b1 && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        check(8'(n == `KBL_ACK_TIMEOUT_CYC), 8'h01, "timeout span");
        @(negedge i_clk);
        check({7'h00, ack_to}, 8'h00, "timeout pulse");
        expect_tx(8'hff);
        expect_none;
        host_u.send(8'h31);
        expect_tx(8'hff);
        restart(8'h30);
        host_u.send(8'hff);
        expect_tx(8'hff);
        host_u.send(8'hfd);
        expect_tx(8'hff);
        for (int i = 0; i < 4; i++) restart(8'h30 + 8'(i));
        $display("test restart sequence done");
        restart(8'h31);
        key_packet(1'b1, 8'h3f, 8'h33);
        key_packet(1'b0, 8'h3f, 8'h31);
        key_packet(1'b1, 8'h3f, 8'h30);
        offer_key(9'h1a5);
        expect_none;
        restart(8'h31);
        key_packet(1'b1, 8'h30, 8'h30);
        $display("test key packets done");
        restart(8'h33);
        step(4'h1);
        mouse_packet(8'h31);
        repeat (3) step(4'h8);
        step(4'h2);
        expect_none;
        host_u.send(8'h22);
        mouse_packet(8'h30);
        $display("test mouse reports done");
        host_u.send(8'h05);
        expect_none;
        check({5'h00, leds}, 8'h05, "leds");
        step(4'h8);
        restart(8'h30);
        check({5'h00, leds}, 8'h05, "leds kept");
        host_u.send(8'h22);
        mouse_packet(8'h30);
        restart(8'h31);
        stall = 1'b1;
        offer_key(9'h134);
        i_user_rst = 1'b1;
        repeat (4) @(negedge i_clk);
        i_user_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        stall = 1'b0;
        expect_tx(8'hff);
        expect_none;
        restart(8'h30);
        check(8'(host_u.hold_errs), 8'h00, "stalled byte held");
        $display("test leds and user reset done");
        give_verdict;
    end
endmodule // kbl_link_tb
`default_nettype wire
